// >>> cbg_pkg.sv
// Constants, carriers and state type for the caption bridge and cue block
package cbg_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 50_000_000;
	localparam int TIMEOUT_UNIT_MS = 1;
	localparam int MS_CYCLES_DEF   = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;
	localparam int BAUD_9600       = 9600;
	localparam int BAUD_19200      = 19200;
	localparam int BAUD_38400      = 38400;
	localparam int BAUD_115200     = 115200;
	localparam int DIV_9600        = CLK_HZ / BAUD_9600;
	localparam int DIV_19200       = CLK_HZ / BAUD_19200;
	localparam int DIV_38400       = CLK_HZ / BAUD_38400;
	localparam int DIV_115200      = CLK_HZ / BAUD_115200;

	// ----------------------------------------------------------------
	// Register map (word indices)
	// ----------------------------------------------------------------
	localparam int         AXI_ADDR_W = 8;
	localparam logic [5:0] REG_BRIDGE = 6'h00;
	localparam logic [5:0] REG_BAUD   = 6'h01;
	localparam logic [5:0] REG_ROUTE  = 6'h02;
	localparam logic [5:0] REG_SRC    = 6'h03;
	localparam logic [5:0] REG_INS_A  = 6'h04;
	localparam logic [5:0] REG_INS_B  = 6'h05;
	localparam logic [5:0] REG_LINE_A = 6'h06;
	localparam logic [5:0] REG_LINE_B = 6'h07;
	localparam logic [5:0] REG_CUEOUT = 6'h08;
	localparam logic [5:0] REG_STATUS = 6'h09;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int INS_MODE_LSB = 0;
	localparam int INS_CUE_EN   = 2;
	localparam int INS_CUE_OR   = 3;
	localparam int INS_POL_LSB  = 4;
	localparam int INS_MAP_LSB  = 8;
	localparam int INS_TMO_LSB  = 16;
	localparam int LINE_HD_LSB  = 16;
	localparam int ROUTE_FMT    = 8;
	localparam int CO_MAP_LSB   = 4;
	localparam int CO_CH_LSB    = 12;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] BR_NONE    = 3'h0;
	localparam logic [2:0] BR_AB_BOTH = 3'h1;
	localparam logic [2:0] BR_BA_BOTH = 3'h2;
	localparam logic [2:0] BR_AB_F1   = 3'h3;
	localparam logic [2:0] BR_BA_F1   = 3'h4;
	localparam logic [2:0] BR_BA_F2   = 3'h5;
	localparam logic [1:0] INS_NORMAL = 2'h0;
	localparam logic [1:0] INS_PERM_F0 = 2'h1;
	localparam logic [1:0] INS_PERM_F1 = 2'h2;
	localparam logic [1:0] INS_PERM_BOTH = 2'h3;
	localparam logic [1:0] BAUD_SEL_9600   = 2'h0;
	localparam logic [1:0] BAUD_SEL_19200  = 2'h1;
	localparam logic [1:0] BAUD_SEL_38400  = 2'h2;
	localparam logic [1:0] BAUD_SEL_115200 = 2'h3;
	localparam logic [1:0] CH_NONE    = 2'h0;
	localparam logic [1:0] CH_A       = 2'h1;
	localparam logic [1:0] CH_B       = 2'h2;
	localparam logic [1:0] CH_BOTH    = 2'h3;
	localparam int         NPORTS     = 4;
	localparam logic [1:0] PORT_NET_ONE = 2'h2;
	localparam logic [1:0] PORT_NET_TWO = 2'h3;
	localparam logic [7:0] FRAME_HDR  = 8'h01;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic       field;
		logic [7:0] data;
	} cbg_cap_t;

	typedef struct packed {
		logic        fsync;
		logic        field;
		logic        hd;
		logic [10:0] line;
		logic [3:0]  cue_rx;
	} cbg_vid_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} cbg_ser_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] bits;
	} cbg_cue_t;

	typedef struct packed {
		logic [2:0]        bridge_sel;
		logic [2:0]        bridge_act;
		logic [3:0]        baud_sel;
		logic [9:0]        route;
		logic [7:0]        src;
		logic [1:0][31:0]  ins;
		logic [1:0][31:0]  cline;
		logic [19:0]       cue_cfg;
		logic [1:0][15:0]  baud_cnt;
		logic [1:0]        baud_tick;
		logic [15:0]       ms_cnt;
		logic              ms_tick;
		logic [1:0][15:0]  idle_ms;
		logic [1:0][3:0]   cue_smp;
		logic [1:0][3:0]   cue_rx;
		cbg_cap_t [1:0]    cap_out;
		cbg_ser_t [3:0]    ser_out;
		cbg_ser_t [3:0]    pend;
		cbg_cue_t [1:0]    cue_tx;
		logic [3:0]        cue_pins;
		logic              aw_hold;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic              w_hold;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} cbg_state_t;

	localparam cbg_state_t ST_RESET = '0;

endpackage : cbg_pkg

// >>> cbg_top.sv
// Caption bridge, serial routing and cue bit insertion and extraction
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module cbg_top
	import cbg_pkg::*;
#(
	parameter int MS_CYCLES     = MS_CYCLES_DEF,
	parameter int BAUD_9600_DIV = DIV_9600
) (
	input  wire logic                  CLK_IN,          // 50 MHz clock
	input  wire logic                  RESET_N_IN,      // Async reset, low
	input  wire logic [AXI_ADDR_W-1:0] AXI_AWADDR_IN,   // Write address
	input  wire logic                  AXI_AWVALID_IN,  // Write addr valid
	output var  logic                  AXI_AWREADY_OUT, // Write addr ready
	input  wire logic [31:0]           AXI_WDATA_IN,    // Write data
	input  wire logic [3:0]            AXI_WSTRB_IN,    // Byte strobes
	input  wire logic                  AXI_WVALID_IN,   // Write data valid
	output var  logic                  AXI_WREADY_OUT,  // Write data ready
	output var  logic [1:0]            AXI_BRESP_OUT,   // Write response
	output var  logic                  AXI_BVALID_OUT,  // Response valid
	input  wire logic                  AXI_BREADY_IN,   // Response ready
	input  wire logic [AXI_ADDR_W-1:0] AXI_ARADDR_IN,   // Read address
	input  wire logic                  AXI_ARVALID_IN,  // Read addr valid
	output var  logic                  AXI_ARREADY_OUT, // Read addr ready
	output var  logic [31:0]           AXI_RDATA_OUT,   // Read data
	output var  logic [1:0]            AXI_RRESP_OUT,   // Read response
	output var  logic                  AXI_RVALID_OUT,  // Read data valid
	input  wire logic                  AXI_RREADY_IN,   // Read data ready
	input  wire logic                  LICENSE_OK_IN,   // Key valid, high
	input  wire cbg_vid_t [1:0]        VID_IN,          // Timing, 0=A 1=B
	input  wire cbg_cap_t [1:0]        CAP_IN,          // Decoded captions
	output var  cbg_cap_t [1:0]        CAP_OUT,         // Captions to insert
	input  wire cbg_ser_t [3:0]        SER_RX_IN,       // Port receive bytes
	output var  cbg_ser_t [3:0]        SER_TX_OUT,      // Port send bytes
	output var  logic [1:0]            BAUD_TICK_OUT,   // Bit-rate enables
	input  wire logic [3:0]            CUE_PINS_IN,     // Cue input pins
	output var  logic [3:0]            CUE_PINS_OUT,    // Cue output pins
	output var  cbg_cue_t [1:0]        CUE_TX_OUT       // Cue bits to insert
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic br_into(logic [2:0] act, logic dst, logic fld);
		case (act)
			BR_AB_BOTH: br_into = dst;
			BR_BA_BOTH: br_into = !dst;
			BR_AB_F1:   br_into = dst && !fld;
			BR_BA_F1:   br_into = !dst && !fld;
			BR_BA_F2:   br_into = !dst && fld;
			default:    br_into = 1'b0;
		endcase
	endfunction : br_into

	function automatic logic br_dest(logic [2:0] act);
		br_dest = (act == BR_AB_BOTH) || (act == BR_AB_F1);
	endfunction : br_dest

	function automatic logic ins_on(logic [1:0] mode, logic timed,
			logic fld);
		case (mode)
			INS_NORMAL:    ins_on = timed;
			INS_PERM_F0:   ins_on = !fld;
			INS_PERM_F1:   ins_on = fld;
			INS_PERM_BOTH: ins_on = 1'b1;
			default:       ins_on = 1'b0;
		endcase
	endfunction : ins_on

	function automatic logic [31:0] merge(logic [31:0] old,
			logic [31:0] nw, logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction : merge

	function automatic logic [15:0] baud_div(logic [1:0] sel);
		case (sel)
			BAUD_SEL_19200:  baud_div = 16'(DIV_19200);
			BAUD_SEL_38400:  baud_div = 16'(DIV_38400);
			BAUD_SEL_115200: baud_div = 16'(DIV_115200);
			default:         baud_div = 16'(BAUD_9600_DIV);
		endcase
	endfunction : baud_div

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cbg_state_t s_q;
	cbg_state_t s_d;

	always_comb begin
		logic            lic;
		logic [1:0]      mode;
		logic            timed;
		logic            act;
		logic            other;
		logic [1:0]      bsel;
		logic            net;
		logic [3:0]      mapped;
		logic [1:0]      pos;
		logic [10:0]     cline;
		logic [1:0]      rsel;
		logic            ch;
		logic [1:0]      idx;
		logic            v;
		logic [31:0]     wv;
		logic [31:0]     rd;
		logic            hit;
		cbg_ser_t        sbyte;
		lic    = LICENSE_OK_IN;
		mode   = INS_NORMAL;
		timed  = 1'b0;
		act    = 1'b0;
		other  = 1'b0;
		bsel   = BAUD_SEL_9600;
		net    = 1'b0;
		mapped = 4'h0;
		pos    = 2'h0;
		cline  = 11'h000;
		rsel   = CH_NONE;
		ch     = 1'b0;
		idx    = 2'h0;
		v      = 1'b0;
		wv     = 32'h0000_0000;
		rd     = 32'h0000_0000;
		hit    = 1'b0;
		sbyte  = '0;
		s_d    = s_q;

		// ------------------------------------------------------------
		// Bridge selection, switched at the destination's field start
		// ------------------------------------------------------------
		other = br_dest((s_q.bridge_sel != BR_NONE) ?
			s_q.bridge_sel : s_q.bridge_act);
		if (VID_IN[other].fsync) begin
			s_d.bridge_act = s_q.bridge_sel;
		end

		// ------------------------------------------------------------
		// Millisecond tick for insert timeouts
		// ------------------------------------------------------------
		s_d.ms_tick = 1'b0;
		if (s_q.ms_cnt >= 16'(MS_CYCLES - 1)) begin
			s_d.ms_cnt  = 16'h0000;
			s_d.ms_tick = 1'b1;
		end else begin
			s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
		end

		for (int c = 0; c < 2; c++) begin
			// --------------------------------------------------------
			// Bit-rate divider, forced fast for network ports
			// --------------------------------------------------------
			net = s_q.src[4*c+2] && s_q.src[4*c+1];
			for (int p = 0; p < NPORTS; p++) begin
				if (s_q.route[2*p +: 2] == 2'(c + 1) &&
						(2'(p) == PORT_NET_ONE || 2'(p) == PORT_NET_TWO)) begin
					net = 1'b1;
				end
			end
			bsel = net ? BAUD_SEL_115200 : s_q.baud_sel[2*c +: 2];
			s_d.baud_tick[c] = 1'b0;
			if (s_q.baud_cnt[c] >= baud_div(bsel) - 16'h0001) begin
				s_d.baud_cnt[c]  = 16'h0000;
				s_d.baud_tick[c] = lic;
			end else begin
				s_d.baud_cnt[c] = s_q.baud_cnt[c] + 16'h0001;
			end

			// --------------------------------------------------------
			// Cue input sampling once per field
			// --------------------------------------------------------
			mapped = 4'h0;
			for (int i = 0; i < 4; i++) begin
				pos = s_q.ins[c][INS_MAP_LSB + 2*i +: 2];
				mapped[pos] = mapped[pos] |
					(CUE_PINS_IN[i] ^ s_q.ins[c][INS_POL_LSB + i]);
			end
			if (VID_IN[c].fsync) begin
				s_d.cue_smp[c] = mapped;
			end

			// --------------------------------------------------------
			// Insert timeout tracking
			// --------------------------------------------------------
			sbyte = SER_RX_IN[s_q.src[4*c +: 2]];
			act = (s_q.src[4*c+2] && sbyte.valid) ||
				(VID_IN[c].fsync && mapped != s_q.cue_smp[c]);
			if (act) begin
				s_d.idle_ms[c] = 16'h0000;
			end else if (s_q.ms_tick && s_q.idle_ms[c] != 16'hFFFF) begin
				s_d.idle_ms[c] = s_q.idle_ms[c] + 16'h0001;
			end
			mode  = s_q.ins[c][INS_MODE_LSB +: 2];
			timed = s_q.idle_ms[c] < s_q.ins[c][INS_TMO_LSB +: 16];

			// --------------------------------------------------------
			// Caption stream toward the channel's inserter
			// --------------------------------------------------------
			s_d.cap_out[c] = '0;
			if (CAP_IN[1-c].valid &&
					br_into(s_q.bridge_act, 1'(c), CAP_IN[1-c].field)) begin
				s_d.cap_out[c] = CAP_IN[1-c];
			end else if (s_q.src[4*c+2] &&
					ins_on(mode, timed, VID_IN[c].field)) begin
				s_d.cap_out[c].valid = sbyte.valid;
				s_d.cap_out[c].field = VID_IN[c].field;
				s_d.cap_out[c].data  = sbyte.data;
			end else if (CAP_IN[c].valid &&
					!br_into(s_q.bridge_act, 1'(c), CAP_IN[c].field)) begin
				s_d.cap_out[c] = CAP_IN[c];
			end
			s_d.cap_out[c].valid = s_d.cap_out[c].valid && lic;

			// --------------------------------------------------------
			// Cue bits on the configured line
			// --------------------------------------------------------
			cline = VID_IN[c].hd ?
				s_q.cline[c][LINE_HD_LSB +: 11] : s_q.cline[c][10:0];
			hit = VID_IN[c].line == cline;
			s_d.cue_tx[c].valid = 1'b0;
			if (hit) begin
				s_d.cue_rx[c] = VID_IN[c].cue_rx;
				s_d.cue_tx[c].valid = lic && s_q.ins[c][INS_CUE_EN];
				if (ins_on(mode, timed, VID_IN[c].field)) begin
					s_d.cue_tx[c].bits = s_q.cue_smp[c] |
						(s_q.ins[c][INS_CUE_OR] ?
						VID_IN[c].cue_rx : 4'h0);
				end else begin
					s_d.cue_tx[c].bits = VID_IN[c].cue_rx;
				end
			end
		end

		// ------------------------------------------------------------
		// Cue output pins
		// ------------------------------------------------------------
		for (int j = 0; j < 4; j++) begin
			idx  = s_q.cue_cfg[CO_MAP_LSB + 2*j +: 2];
			rsel = s_q.cue_cfg[CO_CH_LSB + 2*j +: 2];
			v = ((rsel == CH_A || rsel == CH_BOTH) && s_q.cue_rx[0][idx]) ||
				((rsel == CH_B || rsel == CH_BOTH) &&
				s_q.cue_rx[1][idx]);
			s_d.cue_pins[j] = (v && lic) ^ s_q.cue_cfg[j];
		end

		// ------------------------------------------------------------
		// Decoded captions toward the serial ports
		// ------------------------------------------------------------
		for (int p = 0; p < NPORTS; p++) begin
			rsel = s_q.route[2*p +: 2];
			ch   = rsel == CH_B;
			s_d.ser_out[p] = '0;
			if (lic && (rsel == CH_A || rsel == CH_B)) begin
				if (s_q.route[ROUTE_FMT + ch] && VID_IN[ch].fsync) begin
					s_d.ser_out[p].valid = 1'b1;
					s_d.ser_out[p].data  = FRAME_HDR;
					s_d.pend[p].valid    = CAP_IN[ch].valid;
					s_d.pend[p].data     = CAP_IN[ch].data;
				end else if (s_q.pend[p].valid) begin
					s_d.ser_out[p]       = s_q.pend[p];
					s_d.pend[p].valid    = CAP_IN[ch].valid;
					s_d.pend[p].data     = CAP_IN[ch].data;
				end else begin
					s_d.ser_out[p].valid = CAP_IN[ch].valid;
					s_d.ser_out[p].data  = CAP_IN[ch].data;
				end
			end else begin
				s_d.pend[p] = '0;
			end
		end

		// ------------------------------------------------------------
		// Register bus: write path
		// ------------------------------------------------------------
		if (AXI_AWVALID_IN && s_q.awready) begin
			s_d.aw_hold = 1'b1;
			s_d.awaddr  = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && s_q.wready) begin
			s_d.w_hold = 1'b1;
			s_d.wdata  = AXI_WDATA_IN;
			s_d.wstrb  = AXI_WSTRB_IN;
		end
		if (AXI_BREADY_IN && s_q.bvalid) begin
			s_d.bvalid = 1'b0;
		end
		if (s_d.aw_hold && s_d.w_hold && !s_q.bvalid) begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = RESP_OKAY;
			case (s_d.awaddr[7:2])
				REG_BRIDGE: begin
					wv = merge({29'h0, s_q.bridge_sel}, s_d.wdata, s_d.wstrb);
					s_d.bridge_sel = wv[2:0];
				end
				REG_BAUD: begin
					wv = merge({28'h0, s_q.baud_sel}, s_d.wdata, s_d.wstrb);
					s_d.baud_sel = wv[3:0];
				end
				REG_ROUTE: begin
					wv = merge({22'h0, s_q.route}, s_d.wdata, s_d.wstrb);
					s_d.route = wv[9:0];
				end
				REG_SRC: begin
					wv = merge({24'h0, s_q.src}, s_d.wdata, s_d.wstrb);
					s_d.src = wv[7:0];
				end
				REG_INS_A: s_d.ins[0] = merge(s_q.ins[0], s_d.wdata, s_d.wstrb);
				REG_INS_B: s_d.ins[1] = merge(s_q.ins[1], s_d.wdata, s_d.wstrb);
				REG_LINE_A: s_d.cline[0] =
					merge(s_q.cline[0], s_d.wdata, s_d.wstrb);
				REG_LINE_B: s_d.cline[1] =
					merge(s_q.cline[1], s_d.wdata, s_d.wstrb);
				REG_CUEOUT: begin
					wv = merge({12'h0, s_q.cue_cfg}, s_d.wdata, s_d.wstrb);
					s_d.cue_cfg = wv[19:0];
				end
				REG_STATUS: s_d.bresp = RESP_OKAY;
				default: s_d.bresp = RESP_SLVERR;
			endcase
		end
		s_d.awready = !s_d.aw_hold && !s_d.bvalid;
		s_d.wready  = !s_d.w_hold && !s_d.bvalid;

		// ------------------------------------------------------------
		// Register bus: read path
		// ------------------------------------------------------------
		if (AXI_RREADY_IN && s_q.rvalid) begin
			s_d.rvalid = 1'b0;
		end
		if (AXI_ARVALID_IN && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			case (AXI_ARADDR_IN[7:2])
				REG_BRIDGE: rd = {25'h0, s_q.bridge_act, 1'b0, s_q.bridge_sel};
				REG_BAUD:   rd = {28'h0, s_q.baud_sel};
				REG_ROUTE:  rd = {22'h0, s_q.route};
				REG_SRC:    rd = {24'h0, s_q.src};
				REG_INS_A:  rd = s_q.ins[0];
				REG_INS_B:  rd = s_q.ins[1];
				REG_LINE_A: rd = s_q.cline[0];
				REG_LINE_B: rd = s_q.cline[1];
				REG_CUEOUT: rd = {12'h0, s_q.cue_cfg};
				REG_STATUS: rd = {8'h0, s_q.cue_rx[1], s_q.cue_rx[0],
					s_q.cue_smp[0], s_q.cue_pins, 1'b0, s_q.bridge_act,
					4'h0};
				default: begin
					rd = 32'h0000_0000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
			if (AXI_ARADDR_IN[7:2] == REG_STATUS) begin
				rd[0] = lic;
			end
			s_d.rdata = rd;
		end
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_q <= ST_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign AXI_AWREADY_OUT = s_q.awready;
	assign AXI_WREADY_OUT  = s_q.wready;
	assign AXI_BRESP_OUT   = s_q.bresp;
	assign AXI_BVALID_OUT  = s_q.bvalid;
	assign AXI_ARREADY_OUT = s_q.arready;
	assign AXI_RDATA_OUT   = s_q.rdata;
	assign AXI_RRESP_OUT   = s_q.rresp;
	assign AXI_RVALID_OUT  = s_q.rvalid;
	assign CAP_OUT         = s_q.cap_out;
	assign SER_TX_OUT      = s_q.ser_out;
	assign BAUD_TICK_OUT   = s_q.baud_tick;
	assign CUE_PINS_OUT    = s_q.cue_pins;
	assign CUE_TX_OUT      = s_q.cue_tx;

endmodule : cbg_top

`default_nettype wire

// >>> cbg_monitor.sv
// Checker for bus handshakes and output gating of the caption block
`timescale 1ns/1ns
`default_nettype none
module cbg_monitor
	import cbg_pkg::*;
(
	input wire logic           CLK_IN,          // Clock
	input wire logic           RESET_N_IN,      // Reset, low
	input wire logic           LICENSE_OK_IN,   // Key valid
	input wire logic           AXI_AWVALID_IN,  // Write addr valid
	input wire logic           AXI_AWREADY_OUT, // Write addr ready
	input wire logic           AXI_WVALID_IN,   // Write data valid
	input wire logic           AXI_WREADY_OUT,  // Write data ready
	input wire logic           AXI_BVALID_OUT,  // Response valid
	input wire logic           AXI_BREADY_IN,   // Response ready
	input wire logic           AXI_ARVALID_IN,  // Read addr valid
	input wire logic           AXI_ARREADY_OUT, // Read addr ready
	input wire logic           AXI_RVALID_OUT,  // Read data valid
	input wire logic           AXI_RREADY_IN,   // Read data ready
	input wire logic [1:0]     AXI_BRESP_OUT,   // Write response
	input wire logic [1:0]     BAUD_TICK_OUT,   // Bit-rate ticks
	input wire logic [31:0]    AXI_RDATA_OUT,   // Read data
	input wire cbg_cap_t [1:0] CAP_IN,          // Captions in
	input wire cbg_cap_t [1:0] CAP_OUT,         // Captions out
	input wire cbg_ser_t [3:0] SER_RX_IN,       // Port bytes in
	input wire cbg_ser_t [3:0] SER_TX_OUT,      // Port bytes out
	input wire cbg_cue_t [1:0] CUE_TX_OUT       // Cue bits
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	wire logic any_in = CAP_IN[0].valid | CAP_IN[1].valid | SER_RX_IN[0].valid
		| SER_RX_IN[1].valid | SER_RX_IN[2].valid | SER_RX_IN[3].valid;
	wire logic out_on = CAP_OUT[0].valid | CAP_OUT[1].valid | (|BAUD_TICK_OUT)
		| CUE_TX_OUT[0].valid | CUE_TX_OUT[1].valid | SER_TX_OUT[0].valid
		| SER_TX_OUT[1].valid | SER_TX_OUT[2].valid | SER_TX_OUT[3].valid;
	sequence ar_take;
		AXI_ARVALID_IN && AXI_ARREADY_OUT;
	endsequence
	sequence wr_take;
		AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
	endsequence
	rd_answer_a: assert property (ar_take |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT)
		else $error("read answer missing");
	rd_hold_a: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
		AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("read data lost");
	wr_answer_a: assert property (wr_take |=> AXI_BVALID_OUT)
		else $error("write answer missing");
	wr_hold_a: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
		AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("response lost");
	wr_block_a: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT
		&& !AXI_WREADY_OUT) else $error("write taken during response");
	licence_gate_a: assert property (!LICENSE_OK_IN |=> !out_on)
		else $error("output active without key");
	tick_gap_a: assert property (BAUD_TICK_OUT[0] |=> !BAUD_TICK_OUT[0] [*3])
		else $error("bit-rate ticks too close");
	cap_cause_a: assert property (CAP_OUT[0].valid | CAP_OUT[1].valid |->
		$past(any_in)) else $error("caption byte without source");
endmodule : cbg_monitor
bind cbg_top cbg_monitor i_cbg_monitor (.CLK_IN, .RESET_N_IN, .LICENSE_OK_IN,
	.AXI_AWVALID_IN, .AXI_AWREADY_OUT, .AXI_WVALID_IN, .AXI_WREADY_OUT,
	.AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARVALID_IN, .AXI_ARREADY_OUT,
	.AXI_RVALID_OUT, .AXI_RREADY_IN, .AXI_BRESP_OUT, .BAUD_TICK_OUT,
	.AXI_RDATA_OUT, .CAP_IN, .CAP_OUT, .SER_RX_IN, .SER_TX_OUT, .CUE_TX_OUT);
`default_nettype wire

// >>> cbg_host_model.sv
// Caption host on the serial ports
`timescale 1ns/1ns
`default_nettype none
module cbg_host_model
	import cbg_pkg::*;
(
	input  wire logic           clk_in,   // Clock
	input  wire logic           rst_n_in, // Reset, low
	input  wire logic           send_in,  // Send one byte
	input  wire logic [1:0]     port_in,  // Target port
	input  wire logic [7:0]     byte_in,  // Byte to send
	input  wire cbg_ser_t [3:0] tx_in,    // Bytes from block
	output var  cbg_ser_t [3:0] rx_out,   // Bytes to block
	output var  logic [7:0]     last_out  // Last byte seen
);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_out <= '0;
			last_out <= '0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				// Idle port inverts its data every cycle rather than holding the last byte
				rx_out[p].valid <= send_in && port_in == p;
				rx_out[p].data <= (send_in && port_in == p) ? byte_in : ~rx_out[p].data;
				if (tx_in[p].valid) last_out <= tx_in[p].data;
			end
		end
	end
endmodule : cbg_host_model
`default_nettype wire

// >>> tb.sv
// Register-level bench for the caption bridge and cue block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cbg_pkg::*;
	logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic lic = 1, snd = 0, awr, wr, bv, arr, rv;
	logic [7:0] awa = '0, ara = '0, hb = '0, hrx;
	logic [31:0] wd = '0, rdt, q;
	logic [1:0] br, rr, rs, tick, hp = '0;
	logic [3:0] pin = '0, pout;
	cbg_vid_t [1:0] vid = '0;
	cbg_cap_t [1:0] cin = '0, cout;
	cbg_ser_t [3:0] srx, stx;
	cbg_cue_t [1:0] ctx;
	int miscompares = 0, tests_run = 0, n;
	// Bridge cases: mode, source, field, expect, key
	localparam logic [6:0] BT [9] = '{{BR_AB_BOTH, 4'h7}, {BR_AB_BOTH, 4'h0},
		{BR_BA_BOTH, 4'hB}, {BR_AB_F1, 4'h3}, {BR_AB_F1, 4'h5}, {BR_BA_F1, 4'hB},
		{BR_BA_F2, 4'hF}, {BR_BA_F2, 4'h9}, {BR_NONE, 4'h1}};
	localparam int DV [4] = '{8, DIV_19200, DIV_38400, DIV_115200};
	always #10 clk = ~clk;
	cbg_top #(.MS_CYCLES(10), .BAUD_9600_DIV(8)) i_cbg_top (.CLK_IN(clk),
		.RESET_N_IN(rst_n), .LICENSE_OK_IN(lic), .AXI_AWADDR_IN(awa),
		.AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd),
		.AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr),
		.AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry),
		.AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
		.AXI_RDATA_OUT(rdt), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv),
		.AXI_RREADY_IN(rry), .VID_IN(vid), .CAP_IN(cin), .CAP_OUT(cout),
		.SER_RX_IN(srx), .SER_TX_OUT(stx), .BAUD_TICK_OUT(tick),
		.CUE_PINS_IN(pin), .CUE_PINS_OUT(pout), .CUE_TX_OUT(ctx));
	cbg_host_model i_cbg_host_model (.clk_in(clk), .rst_n_in(rst_n),
		.send_in(snd), .port_in(hp), .byte_in(hb), .tx_in(stx),
		.rx_out(srx), .last_out(hrx));
	task automatic report_and_stop;
		if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One bus transfer: w=1 write, w=0 read into q
	task automatic ax(input logic w, input logic [5:0] a, input logic [31:0] d);
		{awa, ara, wd} <= {a, 2'h0, a, 2'h0, d};
		{awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
		n = 0;
		do begin
			@(posedge clk);
			if (awr & awv) awv <= 0;
			if (wr & wv) wv <= 0;
			if (arr & arv) arv <= 0;
			if (bv & bry) begin
				bry <= 0;
				rs = br;
			end
			if (rv & rry) begin
				rry <= 0;
				rs = rr;
				q = rdt;
			end
		end while ((awv | wv | bry | arv | rry) && n++ < 99);
		if (n > 98) begin
			miscompares++;
			report_and_stop;
		end
	endtask : ax
	task automatic fs(input logic f);
		vid[0].field <= f;
		vid[1].field <= f;
		{vid[0].fsync, vid[1].fsync} <= 2'h3;
		@(posedge clk);
		{vid[0].fsync, vid[1].fsync} <= 2'h0;
		@(posedge clk);
	endtask : fs
	task automatic per(input int c, input int d);
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!tick[c] && n < 6000);
			if (n >= 6000) begin
				miscompares++;
				report_and_stop;
			end
		end
		chk(n, d);
	endtask : per
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		ax(0, REG_BRIDGE, 0);
		chk(q, 0);
		ax(0, 6'h0A, 0);
		chk({rs, q}, {RESP_SLVERR, 32'h0});
		ax(1, 6'h0A, 32'hFFFF_FFFF);
		chk(rs, RESP_SLVERR);
		foreach (BT[i]) begin
			lic <= BT[i][0];
			ax(1, REG_BRIDGE, BT[i][6:4]);
			fs(BT[i][2]);
			cin[BT[i][3]] <= {1'b1, BT[i][2], 8'hA5};
			@(posedge clk);
			cin[BT[i][3]].valid <= 0;
			@(posedge clk);
			chk(cout[!BT[i][3]] & {10{cout[!BT[i][3]].valid}},
				BT[i][1] ? {1'b1, BT[i][2], 8'hA5} : 10'h0);
		end
		ax(1, REG_BRIDGE, BR_AB_F1);
		ax(0, REG_BRIDGE, 0);
		chk(q, 32'h03);
		fs(0);
		ax(0, REG_BRIDGE, 0);
		chk(q, 32'h33);
		ax(1, REG_BRIDGE, BR_NONE);
		fs(0);
		ax(1, REG_LINE_A, 32'h0A);
		ax(1, REG_CUEOUT, 32'h0001_5101);
		pin <= 4'h1;
		for (int m = 0; m < 2; m++) begin
			ax(1, REG_INS_A, m ? 32'h1B2F : 32'h1B2C);
			fs(0);
			{vid[0].line, vid[0].cue_rx} <= {11'h0A, 4'h1};
			@(posedge clk);
			vid[0].line <= 11'h0;
			@(posedge clk);
			chk(ctx[0], m ? 5'h1D : 5'h11);
			repeat (2) @(posedge clk);
			chk(pout, 4'h2);
		end
		for (int b = 0; b < 4; b++) begin
			ax(1, REG_BAUD, b << 2);
			per(1, DV[b]);
		end
		ax(1, REG_ROUTE, 32'h10);
		per(0, DIV_115200);
		cin[0] <= {1'b1, 1'b0, 8'h3C};
		@(posedge clk);
		cin[0].valid <= 0;
		repeat (3) @(posedge clk);
		chk(hrx, 8'h3C);
		ax(1, REG_ROUTE, 32'h110);
		fs(0);
		@(posedge clk);
		chk(hrx, FRAME_HDR);
		ax(1, REG_SRC, 32'h5);
		{hp, hb, snd} <= {2'h1, 8'h77, 1'b1};
		@(posedge clk);
		snd <= 0;
		repeat (2) @(posedge clk);
		chk({cout[0].valid, cout[0].data}, 9'h177);
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
